/* File: logic/prc_defs.svh */
`ifndef PRC_DEFS_SVH
`define PRC_DEFS_SVH
`define PRC_ADDR_LIM_BIT 39
`define PRC_CFG_EXT_BASE 12'h100
`define PRC_NUM_LANES 4
`define PRC_NUM_TC 8
`define PRC_MAP_RST_VC 1'b0
`define PRC_CLK_MHZ 100
`define PRC_POLL_NS 1000
`define PRC_POLL_CYC ((`PRC_POLL_NS * `PRC_CLK_MHZ + 999) / 1000)
`define PRC_RATE_MAX 2'h3
`define PRC_RATE_16G 2'h3
`define PRC_LANE0_CTRL0 4'h0
`define PRC_LANE0_CTRL1 4'h8
`define PRC_LANE0_CTRL2 4'hc
`define PRC_LANE0_REV_X8 4'hf
`endif

/* File: logic/prc_pkg.sv */
package prc_pkg;
  typedef enum logic [2:0] {TR_DETECT, TR_POLL, TR_CFG, TR_RATE, TR_L0} prc_train_e;
  typedef struct packed {
    logic [63:0] addr;
    logic [2:0] tc;
    logic wr;
    logic [31:0] data;
  } prc_req_s;
  typedef struct packed {
    logic [63:0] addr;
    logic [2:0] tc;
    logic vc;
    logic is_cfg;
    logic ext;
    logic wr;
    logic [31:0] data;
  } prc_tx_s;
  typedef struct packed {
    logic [63:0] addr;
    logic wr;
    logic [31:0] data;
  } prc_up_s;
endpackage

/* File: logic/prc_root_port.sv */
// Overview of operation
// [R1] Downstream addresses always leave with bits 63 to 39 cleared.
// [R2] Upstream reads at or above 512 GB get an Unsupported Request answer.
// [R3] Upstream writes at or above 512 GB are dropped, never forwarded.
// [R4] Configuration completions with retry status cause automatic reissue.
// [R5] Configuration space is 4 KB; offsets from 100h up are extended.
// [R6] Flat memory-mapped accesses become configuration requests on the link.
// [R7] After reset the link is detected, negotiated and trained autonomously.
// [R8] Each lane detects and corrects its own polarity during training.
// [R9] Rates 2.5, 5, 8 and 16 GT/s are negotiated during training.
// [R10] At 16 GT/s the link uses 128b/130b encoding.
// [R11] A narrower partner trains at reduced width; no further port split.
// [R12] Controller lane 0 sits on physical lane 0, 8 or 12.
// [R13] Reversed single x8 uses lanes 8 to 15, lane 15 logical zero.
// [R14] A programmable class_to_channel_map picks the virtual channel.
// [R15] Power management messages from below become host events.
// [R16] Range checks act on the header in its decode cycle.
`timescale 1ns/1ps
`include "prc_defs.svh"
module prc_root_port
  import prc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [3:0] i_rx_det,
  input wire logic [3:0] i_rx_inv,
  input wire logic [1:0] i_partner_rate,
  input wire logic [1:0] i_strap_ctrl,
  input wire logic i_strap_rev,
  input wire logic i_dn_vld,
  input wire prc_req_s i_dn,
  output logic o_dn_rdy,
  input wire logic i_ecam_vld,
  input wire logic [27:0] i_ecam_addr,
  input wire logic i_ecam_wr,
  input wire logic [31:0] i_ecam_data,
  output logic o_ecam_rdy,
  output logic o_ecam_done,
  output logic [31:0] o_ecam_rdata,
  input wire logic i_cpl_vld,
  input wire logic i_cpl_crs,
  input wire logic [31:0] i_cpl_data,
  output logic o_tx_vld,
  output prc_tx_s o_tx,
  input wire logic i_up_vld,
  input wire prc_up_s i_up,
  output logic o_mem_vld,
  output prc_up_s o_mem,
  output logic o_ur_vld,
  output logic [63:0] o_ur_addr,
  input wire logic i_map_we,
  input wire logic [2:0] i_map_tc,
  input wire logic i_map_vc,
  input wire logic i_pme_vld,
  input wire logic [15:0] i_pme_rid,
  output logic o_pme_evt,
  output logic [15:0] o_pme_rid,
  output logic o_link_up,
  output logic [2:0] o_width,
  output logic [1:0] o_rate,
  output logic o_enc_128b,
  output logic [3:0] o_lane_inv,
  output logic [3:0] o_lane0_phys,
  output logic o_lane_rev
);
  localparam int SYNC_W = 13;
  localparam logic [7:0] POLL_LAST = 8'(`PRC_POLL_CYC - 1);

  // Pin level inputs pass two flops; only the second stage is read.
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {i_strap_rev, i_strap_ctrl, i_partner_rate, i_rx_inv, i_rx_det};
      sync2_r <= sync1_r;
    end
  end
  logic [3:0] s_det;
  logic [3:0] s_inv;
  logic [1:0] s_prate;
  logic [1:0] s_ctrl;
  logic s_rev;
  assign s_det = sync2_r[3:0];
  assign s_inv = sync2_r[7:4];
  assign s_prate = sync2_r[9:8];
  assign s_ctrl = sync2_r[11:10];
  assign s_rev = sync2_r[12];

  // Lane placement straps are caught once, a few cycles after release.
  logic strap_done_r;
  logic [1:0] strap_cnt_r;
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      strap_cnt_r <= 2'h0;
      strap_done_r <= 1'b0;
      o_lane0_phys <= `PRC_LANE0_CTRL0;
      o_lane_rev <= 1'b0;
    end else if (!strap_done_r) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_cnt_r == 2'h3) begin
        strap_done_r <= 1'b1;
        o_lane_rev <= s_rev;
        if (s_rev) begin
          o_lane0_phys <= `PRC_LANE0_REV_X8; // [R13]
        end else begin
          case (s_ctrl) // [R12]
            2'h1: o_lane0_phys <= `PRC_LANE0_CTRL1;
            2'h2: o_lane0_phys <= `PRC_LANE0_CTRL2;
            default: o_lane0_phys <= `PRC_LANE0_CTRL0;
          endcase
        end
      end
    end
  end

  // Training sequencer; the partner presence on lane 0 gates everything.
  prc_train_e tr_r;
  logic [7:0] poll_cnt_r;
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      tr_r <= TR_DETECT;
      poll_cnt_r <= 8'h0;
      o_link_up <= 1'b0;
      o_width <= 3'h0;
      o_rate <= 2'h0;
      o_enc_128b <= 1'b0;
    end else begin
      case (tr_r) // [R7]
        TR_DETECT: begin
          o_link_up <= 1'b0;
          poll_cnt_r <= 8'h0;
          if (s_det[0] && strap_done_r) begin
            tr_r <= TR_POLL;
          end
        end
        TR_POLL: begin
          poll_cnt_r <= poll_cnt_r + 8'h1;
          if (!s_det[0]) begin
            tr_r <= TR_DETECT;
          end else if (poll_cnt_r == POLL_LAST) begin
            tr_r <= TR_CFG;
          end
        end
        TR_CFG: begin
          // Only contiguous lanes from lane 0 count; the port never splits.
          if (&s_det) begin // [R11]
            o_width <= 3'h4;
          end else if (&s_det[1:0]) begin
            o_width <= 3'h2;
          end else begin
            o_width <= 3'h1;
          end
          tr_r <= s_det[0] ? TR_RATE : TR_DETECT;
        end
        TR_RATE: begin
          // Lowest common rate: 0 is 2.5, 1 is 5, 2 is 8, 3 is 16 GT/s.
          o_rate <= (s_prate < `PRC_RATE_MAX) ? s_prate : `PRC_RATE_MAX; // [R9]
          o_enc_128b <= (s_prate >= `PRC_RATE_16G); // [R10]
          tr_r <= TR_L0;
        end
        TR_L0: begin
          o_link_up <= s_det[0];
          if (!s_det[0]) begin
            tr_r <= TR_DETECT;
          end
        end
        default: tr_r <= TR_DETECT;
      endcase
    end
  end

  // Per-lane polarity is latched during polling with no setting needed.
  genvar gl;
  generate
    for (gl = 0; gl < `PRC_NUM_LANES; gl++) begin : g_lane
      always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
          o_lane_inv[gl] <= 1'b0;
        end else if (tr_r == TR_POLL) begin
          o_lane_inv[gl] <= s_inv[gl]; // [R8]
        end
      end
    end
  endgenerate

  // Traffic class to virtual channel table, one flop per class.
  logic [`PRC_NUM_TC-1:0] map_r;
  genvar gt;
  generate
    for (gt = 0; gt < `PRC_NUM_TC; gt++) begin : g_map
      always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
          map_r[gt] <= `PRC_MAP_RST_VC; // [R14]
        end else if (i_map_we && (i_map_tc == 3'(gt))) begin
          map_r[gt] <= i_map_vc; // [R14]
        end
      end
    end
  endgenerate

  // Downstream issue: configuration has priority, retry over both.
  logic cfg_pend_r;
  prc_tx_s cfg_hdr_r;
  logic retry;
  logic cpl_ok;
  logic ecam_take;
  logic dn_take;
  logic [11:0] ecam_off;
  prc_tx_s ecam_hdr;
  prc_tx_s dn_hdr;
  assign retry = cfg_pend_r && i_cpl_vld && i_cpl_crs;
  assign cpl_ok = cfg_pend_r && i_cpl_vld && !i_cpl_crs;
  assign ecam_take = i_ecam_vld && o_ecam_rdy;
  assign dn_take = i_dn_vld && o_dn_rdy && !ecam_take && !retry;
  assign ecam_off = i_ecam_addr[11:0];

  always_comb begin
    ecam_hdr = '0;
    ecam_hdr.addr = {36'h0, i_ecam_addr}; // [R6]
    ecam_hdr.is_cfg = 1'b1;
    ecam_hdr.ext = (ecam_off >= `PRC_CFG_EXT_BASE); // [R5]
    ecam_hdr.wr = i_ecam_wr;
    ecam_hdr.data = i_ecam_data;
    dn_hdr = '0;
    dn_hdr.addr = i_dn.addr;
    dn_hdr.addr[63:`PRC_ADDR_LIM_BIT] = '0; // [R1] [R16]
    dn_hdr.tc = i_dn.tc;
    dn_hdr.vc = map_r[i_dn.tc]; // [R14]
    dn_hdr.wr = i_dn.wr;
    dn_hdr.data = i_dn.data;
  end

  logic cfg_pend_nxt;
  assign cfg_pend_nxt = ecam_take || (cfg_pend_r && !cpl_ok);

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_pend_r <= 1'b0;
      cfg_hdr_r <= '0;
      o_ecam_rdy <= 1'b0;
      o_dn_rdy <= 1'b0;
    end else begin
      cfg_pend_r <= cfg_pend_nxt;
      if (ecam_take) begin
        cfg_hdr_r <= ecam_hdr;
      end
      // ECAM ready drops the cycle after a take, so one access is in flight.
      o_ecam_rdy <= o_link_up && !cfg_pend_nxt;
      o_dn_rdy <= o_link_up;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_tx_vld <= 1'b0;
      o_tx <= '0;
    end else begin
      o_tx_vld <= retry || ecam_take || dn_take;
      if (retry) begin
        o_tx <= cfg_hdr_r; // [R4]
      end else if (ecam_take) begin
        o_tx <= ecam_hdr;
      end else if (dn_take) begin
        o_tx <= dn_hdr;
      end
    end
  end

  // A retry status is never shown to the requester; only a final answer is.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ecam_done <= 1'b0;
      o_ecam_rdata <= 32'h0;
    end else begin
      o_ecam_done <= cpl_ok; // [R4]
      if (cpl_ok) begin
        o_ecam_rdata <= i_cpl_data;
      end
    end
  end

  // Upstream policing on the header in the cycle it arrives.
  logic up_hi;
  assign up_hi = |i_up.addr[63:`PRC_ADDR_LIM_BIT]; // [R16]
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mem_vld <= 1'b0;
      o_mem <= '0;
      o_ur_vld <= 1'b0;
      o_ur_addr <= 64'h0;
    end else begin
      o_mem_vld <= i_up_vld && !up_hi; // [R3]
      if (i_up_vld && !up_hi) begin
        o_mem <= i_up;
      end
      o_ur_vld <= i_up_vld && up_hi && !i_up.wr; // [R2]
      if (i_up_vld && up_hi && !i_up.wr) begin
        o_ur_addr <= i_up.addr;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pme_evt <= 1'b0;
      o_pme_rid <= 16'h0;
    end else begin
      o_pme_evt <= i_pme_vld; // [R15]
      if (i_pme_vld) begin
        o_pme_rid <= i_pme_rid;
      end
    end
  end
endmodule

/* File: tb/prc_props.sv */
`timescale 1ns/1ps
module prc_props
  import prc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_ecam_vld,
  input wire logic o_ecam_rdy,
  input wire logic o_ecam_done,
  input wire logic i_cpl_vld,
  input wire logic i_cpl_crs,
  input wire logic o_tx_vld,
  input wire prc_tx_s o_tx,
  input wire logic i_up_vld,
  input wire prc_up_s i_up,
  input wire logic o_mem_vld,
  input wire logic o_ur_vld,
  input wire logic [63:0] o_ur_addr,
  input wire logic i_pme_vld,
  input wire logic o_pme_evt,
  input wire logic o_link_up,
  input wire logic [1:0] o_rate,
  input wire logic o_enc_128b,
  input wire logic [3:0] o_lane0_phys,
  input wire logic o_lane_rev,
  input wire logic [1:0] i_strap_ctrl,
  input wire logic i_strap_rev
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  sequence s_crs;
    i_cpl_vld && i_cpl_crs;
  endsequence
  sequence s_reissue;
    o_tx_vld && o_tx.is_cfg && !o_ecam_done;
  endsequence
  property p_dn_range;
    o_tx_vld && !o_tx.is_cfg |-> o_tx.addr[63:39] == 25'h0;
  endproperty
  a_dn_range: assert property (p_dn_range) else $error("downstream address too high");
  property p_ur;
    i_up_vld && !i_up.wr && i_up.addr[63:39] != 25'h0 |=>
      o_ur_vld && !o_mem_vld && o_ur_addr == $past(i_up.addr);
  endproperty
  a_ur: assert property (p_ur) else $error("high read not refused");
  property p_drop;
    i_up_vld && i_up.wr && i_up.addr[63:39] != 25'h0 |=> !o_mem_vld && !o_ur_vld;
  endproperty
  a_drop: assert property (p_drop) else $error("high write not dropped");
  property p_fwd;
    i_up_vld && i_up.addr[63:39] == 25'h0 |=> o_mem_vld && !o_ur_vld;
  endproperty
  a_fwd: assert property (p_fwd) else $error("low request not forwarded");
  property p_retry;
    s_crs |=> s_reissue;
  endproperty
  a_retry: assert property (p_retry) else $error("retry not reissued");
  property p_done;
    o_ecam_done |-> $past(i_cpl_vld && !i_cpl_crs);
  endproperty
  a_done: assert property (p_done) else $error("done without final completion");
  property p_ext;
    o_tx_vld && o_tx.is_cfg |-> o_tx.ext == (o_tx.addr[11:0] >= 12'h100);
  endproperty
  a_ext: assert property (p_ext) else $error("extended flag wrong");
  property p_take;
    i_ecam_vld && o_ecam_rdy |=> o_tx_vld && o_tx.is_cfg && !o_ecam_rdy;
  endproperty
  a_take: assert property (p_take) else $error("flat access not issued");
  property p_enc;
    o_link_up |-> o_enc_128b == (o_rate == 2'h3);
  endproperty
  a_enc: assert property (p_enc) else $error("encoding flag wrong");
  property p_lane;
    o_link_up |-> o_lane_rev == i_strap_rev && o_lane0_phys == (i_strap_rev ? 4'hf :
      i_strap_ctrl == 2'h1 ? 4'h8 : i_strap_ctrl == 2'h2 ? 4'hc : 4'h0);
  endproperty
  a_lane: assert property (p_lane) else $error("lane zero misplaced");
  property p_pme;
    i_pme_vld |=> o_pme_evt;
  endproperty
  a_pme: assert property (p_pme) else $error("event missing");
endmodule
bind prc_root_port prc_props i_props (.*);

/* File: tb/prc_partner.sv */
`timescale 1ns/1ps
module prc_partner
  import prc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_tx_vld,
  input wire prc_tx_s i_tx,
  input wire logic [1:0] i_retries,
  input wire logic [3:0] i_dly,
  input wire logic [31:0] i_rdata,
  output logic o_cpl_vld,
  output logic o_cpl_crs,
  output logic [31:0] o_cpl_data
);
  logic [3:0] wait_r;
  logic [1:0] tries_r;
  logic busy_r;
  // Idle data toggles so a stale value is never mistaken for an answer.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_cpl_vld <= 1'b0;
      o_cpl_crs <= 1'b0;
      o_cpl_data <= 32'h0;
      busy_r <= 1'b0;
      wait_r <= 4'h0;
      tries_r <= 2'h0;
    end else begin
      o_cpl_vld <= 1'b0;
      o_cpl_crs <= ~o_cpl_crs;
      o_cpl_data <= ~o_cpl_data;
      if (i_tx_vld && i_tx.is_cfg) begin
        busy_r <= 1'b1;
        wait_r <= i_dly;
      end else if (busy_r && wait_r != 4'h0) begin
        wait_r <= wait_r - 4'h1;
      end else if (busy_r) begin
        busy_r <= 1'b0;
        o_cpl_vld <= 1'b1;
        o_cpl_crs <= tries_r < i_retries;
        tries_r <= (tries_r < i_retries) ? tries_r + 2'h1 : 2'h0;
        o_cpl_data <= i_rdata;
      end
    end
  end
endmodule

/* File: tb/tb_prc_root_port.sv */
`timescale 1ns/1ps
module tb_prc_root_port;
  import prc_pkg::*;
  logic i_mclk, i_resetn, i_strap_rev, i_dn_vld, o_dn_rdy, i_ecam_vld, i_ecam_wr;
  logic o_ecam_rdy, o_ecam_done, i_cpl_vld, i_cpl_crs, o_tx_vld, i_up_vld, o_mem_vld;
  logic o_ur_vld, i_map_we, i_map_vc, i_pme_vld, o_pme_evt, o_link_up, o_enc_128b, o_lane_rev;
  logic [3:0] i_rx_det, i_rx_inv, o_lane_inv, o_lane0_phys, dly;
  logic [1:0] i_partner_rate, i_strap_ctrl, tries, o_rate;
  logic [2:0] i_map_tc, o_width;
  logic [27:0] i_ecam_addr;
  logic [31:0] i_ecam_data, o_ecam_rdata, i_cpl_data, rd;
  logic [15:0] i_pme_rid, o_pme_rid;
  logic [63:0] o_ur_addr;
  prc_req_s i_dn;
  prc_tx_s o_tx;
  prc_up_s i_up, o_mem;
  logic [68:0] q[$];
  logic [63:0] ua[5] = '{64'h7f_ffff_fffc, 64'h80_0000_0000, 64'h80_0000_0000,
    64'h8000_0000_0000_0000, 64'h1234};
  int fails, n_tests;
  logic [31:0] seed = 32'hd;
  prc_root_port i_dut (.*);
  prc_partner i_partner (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_tx_vld(o_tx_vld),
    .i_tx(o_tx), .i_retries(tries), .i_dly(dly), .i_rdata(rd), .o_cpl_vld(i_cpl_vld),
    .o_cpl_crs(i_cpl_crs), .o_cpl_data(i_cpl_data));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [68:0] pop();
    return q.size() ? q.pop_front() : 'x;
  endfunction
  task automatic chk(input logic [68:0] got, input logic [68:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (fails == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wait_for(ref logic s);
    int k;
    k = 0;
    while (s !== 1'b1) begin
      @(negedge i_mclk);
      k++;
      if (k > 400) begin
        fails++;
        results();
      end
    end
  endtask
  task automatic cfg(input logic [11:0] off, input logic [1:0] r);
    logic [27:0] a;
    a = 28'(rnd());
    a[11:0] = off;
    tries = r;
    dly = 4'(rnd());
    rd = rnd();
    repeat (r + 1) q.push_back({2'h0, 1'b0, 1'b1, off >= 12'h100, 36'h0, a});
    i_ecam_addr = a;
    i_ecam_vld = 1'b1;
    wait_for(o_ecam_rdy);
    @(negedge i_mclk);
    i_ecam_vld = 1'b0;
    wait_for(o_ecam_done);
    chk(69'(o_ecam_rdata), 69'(rd));
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // Results are checked in mid-cycle, well clear of the register updates.
  always @(negedge i_mclk) begin
    if (o_tx_vld) chk({2'h0, o_tx.vc & ~o_tx.is_cfg, o_tx.is_cfg, o_tx.ext & o_tx.is_cfg,
      o_tx.addr}, pop());
    if (o_mem_vld) chk({2'h1, 3'h0, o_mem.addr}, pop());
    if (o_ur_vld) chk({2'h2, 3'h0, o_ur_addr}, pop());
  end
  initial begin
    {i_dn_vld, i_ecam_vld, i_ecam_wr, i_up_vld, i_map_we, i_map_vc, i_pme_vld} = '0;
    i_dn = '0;
    i_up = '0;
    i_map_tc = '0;
    i_ecam_addr = '0;
    i_ecam_data = '0;
    i_pme_rid = '0;
    tries = '0;
    dly = '0;
    rd = '0;
    // Straps are caught once, so every configuration needs its own reset.
    for (int i = 0; i < 4; i++) begin
      logic [14:0] exp_link;
      i_resetn = 1'b0;
      i_rx_det = i == 1 ? 4'h3 : i == 2 ? 4'h1 : 4'hf;
      i_rx_inv = 4'(rnd());
      i_partner_rate = 2'(i);
      i_strap_ctrl = 2'(i);
      i_strap_rev = i == 3;
      repeat (3) @(negedge i_mclk);
      i_resetn = 1'b1;
      wait_for(o_link_up);
      @(negedge i_mclk);
      exp_link = {i == 1 ? 3'h2 : i == 2 ? 3'h1 : 3'h4, 2'(i), i == 3, i_rx_inv,
        i == 3 ? 4'hf : i == 1 ? 4'h8 : i == 2 ? 4'hc : 4'h0, i == 3};
      chk(69'({o_width, o_rate, o_enc_128b, o_lane_inv, o_lane0_phys, o_lane_rev}),
        69'(exp_link));
    end
    i_map_we = 1'b1;
    i_map_tc = 3'h5;
    i_map_vc = 1'b1;
    @(negedge i_mclk);
    i_map_we = 1'b0;
    for (int t = 0; t < 8; t++) begin
      i_dn = '{addr: {rnd(), rnd()}, tc: 3'(t), wr: 1'b1, data: rnd()};
      q.push_back({2'h0, t == 5, 2'h0, i_dn.addr & 64'h7f_ffff_ffff});
      i_dn_vld = 1'b1;
      wait_for(o_dn_rdy);
      @(negedge i_mclk);
    end
    i_dn_vld = 1'b0;
    cfg(12'h0ff, 2'd2);
    cfg(12'h100, 2'd0);
    cfg(12'hffc, 2'd3);
    for (int k = 0; k < 5; k++) begin
      i_up = '{addr: ua[k], wr: k[0], data: rnd()};
      if (ua[k][63:39] == 25'h0) q.push_back({2'h1, 3'h0, ua[k]});
      else if (!k[0]) q.push_back({2'h2, 3'h0, ua[k]});
      i_up_vld = 1'b1;
      @(negedge i_mclk);
    end
    i_up_vld = 1'b0;
    i_pme_rid = 16'(rnd());
    i_pme_vld = 1'b1;
    @(negedge i_mclk);
    i_pme_vld = 1'b0;
    chk(69'({o_pme_evt, o_pme_rid}), 69'({1'b1, i_pme_rid}));
    repeat (5) @(negedge i_mclk);
    chk(69'(q.size()), 69'h0);
    results();
  end
endmodule
